// ---- hdl/i2c_write_slave.v ----
// write-only serial register slave for the two configuration registers
`timescale 1ns/10ps
module i2c_write_slave (
    // clock and reset
    input  wire       ref_clk,
    input  wire       rst_b,
    // serial bus, already synchronised
    input  wire       scl_s,
    input  wire       sda_s,
    output reg        sda_oe,
    // register write strobe
    output reg        wr_stb,
    output reg        wr_sel,
    output reg  [7:0] wr_data
);
`include "video_encoder_defs.vh"
    localparam ST_IDLE = 4'b0001;
    localparam ST_ADDR = 4'b0010;
    localparam ST_SUB  = 4'b0100;
    localparam ST_DATA = 4'b1000;
    reg  [3:0] state;
    reg        scl_d;
    reg        sda_d;
    reg  [7:0] shift;
    reg  [3:0] bit_cnt;
    reg        ack_pend;
    reg        sub_sel;
    wire       scl_rise = scl_s & ~scl_d;
    wire       scl_fall = ~scl_s & scl_d;
    wire       start_c  = scl_s & scl_d & sda_d & ~sda_s;
    wire       stop_c   = scl_s & scl_d & ~sda_d & sda_s;
    wire [7:0] rx       = {shift[6:0], sda_s};
    wire       addr_ok  = (rx[7:1] == `SLV_ADDR_A || rx[7:1] == `SLV_ADDR_B) && !rx[0];
    wire       sub_ok   = (rx == `SUB_MODE) || (rx == `SUB_CMD);
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            state    <= ST_IDLE;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
            shift    <= 8'h00;
            bit_cnt  <= 4'h0;
            ack_pend <= 1'b0;
            sub_sel  <= 1'b0;
            sda_oe   <= 1'b0;
            wr_stb   <= 1'b0;
            wr_sel   <= 1'b0;
            wr_data  <= 8'h00;
        end else begin
            scl_d  <= scl_s;
            sda_d  <= sda_s;
            wr_stb <= 1'b0;
            if (start_c) begin
                state   <= ST_ADDR;
                bit_cnt <= 4'h0;
                sda_oe  <= 1'b0;
            end else if (stop_c) begin
                state  <= ST_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_fall && ack_pend) begin
                sda_oe   <= 1'b1;
                ack_pend <= 1'b0;
            end else if (scl_fall && sda_oe) begin
                sda_oe  <= 1'b0;
                bit_cnt <= 4'h0;
            end else if (scl_rise && !sda_oe && state != ST_IDLE) begin
                shift   <= rx;
                bit_cnt <= bit_cnt + 4'h1;
                if (bit_cnt == 4'h7) begin
                    case (state)
                        ST_ADDR: begin
                            ack_pend <= addr_ok;
                            state    <= addr_ok ? ST_SUB : ST_IDLE;
                        end
                        ST_SUB: begin
                            ack_pend <= sub_ok;
                            sub_sel  <= rx[0];
                            state    <= sub_ok ? ST_DATA : ST_IDLE;
                        end
                        ST_DATA: begin
                            ack_pend <= 1'b1;
                            wr_stb   <= 1'b1;
                            wr_sel   <= sub_sel;
                            wr_data  <= rx;
                        end
                        default: state <= ST_IDLE;
                    endcase
                end else if (bit_cnt == 4'h8) begin
                    bit_cnt <= 4'h0; // nacked byte's ninth clock
                end
            end
        end
    end
endmodule

// ---- hdl/video_encoder_defs.vh ----
// constants and behaviour list for the video encoder timing and control core
// Behaviour
// - ntsc progressive: second equalizing 4-6, burst pause 261/261.5-6, blank to 17/17.5
// - pal interlaced: first eq 311-312.5, vsync 1-2.5, second eq 2.5-5
// - pal interlaced burst pause follows a four-field sequence
// - pal interlaced: 24.5-line blanking over 311-312.5 and 1-23
// - pal progressive: eq from 311/311.5, vsync 1-2.5, burst to 6, blank to 22/22.5
// - ntsc bars start after hblank 127/116/135, lines 858/780/910 samples
// - pal bars start after hblank 142/155, last edge 757/827, lines 864/944
// - serial slave answers address 1000100 or 1000000 with write bit, acks bytes
// - extra data bytes overwrite the same register, no subaddress increment
// - no ack on address mismatch, bad subaddress or read request
// - writes are whole bytes; undefined bits stay zero
// - mode bit 7 chooses pin settings (0) or register settings (1)
// - mode bit 6 chroma format, bit 3 sampling ratio
// - mode bit 5 ntsc setup level, ignored for pal
// - mode bit 4 slave (0) or master (1) sync
// - mode bits 2:0 select the video standard
// - command bit 4 enables subcarrier phase management
// - command bit 3 interlaced (1) or progressive (0) in master mode
// - command bit 2 forces internal color bar
// - command bits 1:0 scale overlay/bar luminance 25/50/75/100 percent
// - setup bit and overlay level update only in vertical blanking
// - color bar wins, else overlay pin picks overlay, else input image
`ifndef VIDEO_ENCODER_DEFS_VH
`define VIDEO_ENCODER_DEFS_VH
`define SLV_ADDR_A      7'h44
`define SLV_ADDR_B      7'h40
`define SUB_MODE        8'h00
`define SUB_CMD         8'h01
`define MODE_RESET      8'h10
`define CMD_RESET       8'h1B
`define CMD_MASK        8'h1F
`define MODE_OVR_BIT    7
`define MODE_CFMT_BIT   6
`define MODE_SETUP_BIT  5
`define MODE_MSTR_BIT   4
`define MODE_RATIO_BIT  3
`define CMD_GLOCK_BIT   4
`define CMD_INTL_BIT    3
`define CMD_BAR_BIT     2
`define STD_N601        3'h0
`define STD_NSQ         3'h1
`define STD_N4FSC       3'h2
`define STD_P601        3'h4
`define STD_PSQ         3'h5
// half-line positions of field markers: line L maps to 2*(L-1)
`define HL_PAL_EQ1      10'h26C
`define HL_PAL_EQ1_EVN  10'h26D
`define HL_PAL_VS_END   10'h003
`define HL_PAL_EQ2_END  10'h008
`define HL_PAL_BLK_I    10'h02C
`define HL_PAL_BLK_P    10'h02A
`define HL_NTSC_EQ2_BEG 10'h006
`define HL_NTSC_EQ2_END 10'h00A
`define HL_NTSC_VS_END  10'h004
`define HL_NTSC_EQ1     10'h208
`define HL_NTSC_EQ1_EVN 10'h209
`define HL_NTSC_BLK_P   10'h020
`define HL_BURST_END    10'h00A
`define HL_PAL_FIELD    10'h271
`define HL_NTSC_FIELD   10'h20D
`define HL_PAL_FIELD_P  10'h270
`define HL_NTSC_FIELD_P 10'h20C
`endif

// ---- hdl/video_encoder_timing_and_control.v ----
// timing, field structure and control registers of the video encoder
`timescale 1ns/10ps
module video_encoder_timing_and_control #(
    parameter RATE_W = 10
) (
    // clock and reset
    input  wire       ref_clk,
    input  wire       rst_b,
    // serial register port
    input  wire       scl,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe,
    // pin straps used when override is clear
    input  wire [2:0] std_pin,
    input  wire       master_pin,
    input  wire       intl_pin,
    // overlay select pin and external sync
    input  wire       overlay_select_pin,
    input  wire       ext_hsync_b,
    input  wire       ext_vsync_b,
    // register contents
    output reg  [7:0] mode_control_reg,
    output reg  [7:0] command_reg,
    // effective controls
    output reg  [2:0] video_std,
    output reg        chroma_twos,
    output reg        ratio_411,
    output reg        setup_off,
    output reg        sync_master,
    output reg        subcarrier_to_horizontal_phase,
    output reg        interlaced,
    output reg  [1:0] lum_scale,
    output reg  [1:0] src_sel,
    // timing outputs
    output reg  [9:0] sample_count,
    output reg  [9:0] half_line,
    output reg  [2:0] field_num,
    output reg        hblank,
    output reg  [2:0] bar_index,
    output reg        eq_pulse,
    output reg        vsync_period,
    output reg        burst_pause,
    output reg        vblank
);
`include "video_encoder_defs.vh"
    reg  [1:0] scl_sync;
    reg  [1:0] sda_sync;
    reg  [1:0] ovl_sync;
    reg  [1:0] hs_sync;
    reg  [1:0] vs_sync;
    reg        hs_d;
    reg        vs_d;
    reg        setup_pend;
    reg  [1:0] level_pend;
    wire       ack_oe;
    wire       wr_stb;
    wire       wr_sel;
    wire [7:0] wr_data;
    reg  [9:0] line_len;
    reg  [9:0] hblank_end;
    reg  [9:0] bar_step;
    reg  [9:0] bar_last;
    reg  [9:0] field_hl;
    reg  [2:0] next_std;
    reg        next_master;
    reg        next_intl;
    reg        is_pal;
    reg        even_field;
    reg        next_eq;
    reg        next_vs;
    reg        next_bp;
    reg        next_vb;
    reg  [9:0] next_bar_edge;
    reg  [9:0] bar_edge;
    reg  [9:0] cur_edge;
    wire       half_tick;
    wire       line_end;
    wire       field_end;
    wire       hs_fall;
    wire       vs_fall;
    // two-flop synchronisers; first stage feeds only the second
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            ovl_sync <= 2'h0;
            hs_sync  <= 2'h3;
            vs_sync  <= 2'h3;
        end else begin
            scl_sync <= {scl_sync[0], scl};
            sda_sync <= {sda_sync[0], sda_in};
            ovl_sync <= {ovl_sync[0], overlay_select_pin};
            hs_sync  <= {hs_sync[0], ext_hsync_b};
            vs_sync  <= {vs_sync[0], ext_vsync_b};
        end
    end
    i2c_write_slave u_slave (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .scl_s   (scl_sync[1]),
        .sda_s   (sda_sync[1]),
        .sda_oe  (ack_oe),
        .wr_stb  (wr_stb),
        .wr_sel  (wr_sel),
        .wr_data (wr_data)
    );
    // effective selections
    always @* begin
        next_std    = mode_control_reg[`MODE_OVR_BIT] ? mode_control_reg[2:0] : std_pin;
        next_master = mode_control_reg[`MODE_OVR_BIT] ? mode_control_reg[`MODE_MSTR_BIT] : master_pin;
        next_intl   = mode_control_reg[`MODE_OVR_BIT] ? command_reg[`CMD_INTL_BIT] : intl_pin;
        is_pal      = video_std[2];
        case (video_std)
            `STD_NSQ: begin
                line_len = 10'd780; hblank_end = 10'd116; bar_step = 10'd81; bar_last = 10'd682;
            end
            `STD_N4FSC: begin
                line_len = 10'd910; hblank_end = 10'd135; bar_step = 10'd95; bar_last = 10'd795;
            end
            `STD_P601: begin
                line_len = 10'd864; hblank_end = 10'd142; bar_step = 10'd88; bar_last = 10'd757;
            end
            `STD_PSQ: begin
                line_len = 10'd944; hblank_end = 10'd155; bar_step = 10'd96; bar_last = 10'd827;
            end
            default: begin
                line_len = 10'd858; hblank_end = 10'd127; bar_step = 10'd89; bar_last = 10'd750;
            end
        endcase
        if (is_pal)
            field_hl = interlaced ? `HL_PAL_FIELD : `HL_PAL_FIELD_P;
        else
            field_hl = interlaced ? `HL_NTSC_FIELD : `HL_NTSC_FIELD_P;
    end
    // compare with >= so a switch to a shorter standard never runs the counters past the end
    assign line_end  = sample_count >= line_len - 10'd1;
    assign half_tick = line_end || (sample_count == (line_len >> 1) - 10'd1);
    assign field_end = half_tick && (half_line >= field_hl - 10'd1);
    assign hs_fall   = hs_d & ~hs_sync[1];
    assign vs_fall   = vs_d & ~vs_sync[1];
    // registers, pending updates and effective controls
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            mode_control_reg <= `MODE_RESET;
            command_reg      <= `CMD_RESET;
            setup_pend       <= 1'b0;
            level_pend       <= 2'h3;
            video_std        <= `STD_N601;
            chroma_twos      <= 1'b0;
            ratio_411        <= 1'b0;
            setup_off        <= 1'b0;
            sync_master      <= 1'b1;
            subcarrier_to_horizontal_phase <= 1'b1;
            interlaced       <= 1'b1;
            lum_scale        <= 2'h3;
            src_sel          <= 2'h0;
            sda_out          <= 1'b0;
            sda_oe           <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            sda_oe  <= ack_oe;
            if (wr_stb && !wr_sel) begin
                mode_control_reg[7:6] <= wr_data[7:6];
                mode_control_reg[4:0] <= wr_data[4:0];
                setup_pend <= wr_data[`MODE_SETUP_BIT];
            end else if (vblank) begin
                mode_control_reg[`MODE_SETUP_BIT] <= setup_pend;
            end
            if (wr_stb && wr_sel) begin
                command_reg[7:5] <= 3'h0;
                command_reg[4:2] <= wr_data[4:2];
                level_pend <= wr_data[1:0];
            end else if (vblank) begin
                command_reg[1:0] <= level_pend;
            end
            video_std    <= next_std;
            chroma_twos  <= mode_control_reg[`MODE_CFMT_BIT];
            ratio_411    <= mode_control_reg[`MODE_RATIO_BIT];
            setup_off    <= mode_control_reg[`MODE_SETUP_BIT] & ~next_std[2];
            sync_master  <= next_master;
            subcarrier_to_horizontal_phase <= command_reg[`CMD_GLOCK_BIT];
            interlaced   <= next_intl;
            lum_scale    <= command_reg[1:0];
            src_sel      <= command_reg[`CMD_BAR_BIT] ? 2'h2 : (ovl_sync[1] ? 2'h1 : 2'h0);
        end
    end
    // horizontal and half-line counters; slave mode realigns on external sync
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            hs_d         <= 1'b1;
            vs_d         <= 1'b1;
            sample_count <= 10'h000;
            half_line    <= 10'h000;
            field_num    <= 3'h0;
            even_field   <= 1'b0;
            hblank       <= 1'b1;
            bar_index    <= 3'h0;
            bar_edge     <= 10'h000;
        end else begin
            hs_d <= hs_sync[1];
            vs_d <= vs_sync[1];
            if ((!sync_master && hs_fall) || line_end)
                sample_count <= 10'h000;
            else
                sample_count <= sample_count + 10'h001;
            if (!sync_master && vs_fall) begin
                half_line <= 10'h000;
            end else if (field_end) begin
                half_line  <= 10'h000;
                field_num  <= field_num + 3'h1;
                even_field <= ~even_field;
            end else if (half_tick) begin
                half_line <= half_line + 10'h001;
            end
            if (line_end) begin
                hblank    <= 1'b1;
                bar_index <= 3'h0;
                bar_edge  <= hblank_end;
            end else if (sample_count == cur_edge && sample_count <= bar_last) begin
                hblank    <= 1'b0;
                bar_index <= hblank ? 3'h0 : bar_index + 3'h1;
                bar_edge  <= next_bar_edge;
            end
        end
    end
    always @* begin
        // blanking end taken live, so a standard change mid-line cannot use a stale edge
        cur_edge      = hblank ? hblank_end : bar_edge;
        next_bar_edge = (cur_edge + bar_step > bar_last) ? bar_last : cur_edge + bar_step;
    end
    // vertical interval decode on half-line position
    always @* begin
        next_eq = 1'b0;
        next_vs = 1'b0;
        next_bp = 1'b0;
        next_vb = 1'b0;
        if (is_pal) begin
            next_vs = half_line < `HL_PAL_VS_END;
            next_eq = (half_line >= `HL_PAL_VS_END && half_line < `HL_PAL_EQ2_END) ||
                      (half_line >= (interlaced || !even_field ? `HL_PAL_EQ1 : `HL_PAL_EQ1_EVN));
            if (interlaced) begin
                next_vb = half_line < `HL_PAL_BLK_I || half_line >= `HL_PAL_EQ1;
                case (field_num[1:0])
                    2'h0: next_bp = half_line < 10'd11;
                    2'h1: next_bp = half_line < 10'd9 || half_line >= 10'd615;
                    2'h2: next_bp = half_line < 10'd8 || half_line >= `HL_PAL_EQ1;
                    default: next_bp = half_line < 10'd11 || half_line >= 10'd617;
                endcase
            end else begin
                next_bp = half_line < `HL_BURST_END ||
                          half_line >= (even_field ? `HL_PAL_EQ1_EVN : `HL_PAL_EQ1);
                next_vb = half_line < (even_field ? `HL_PAL_BLK_P + 10'd1 : `HL_PAL_BLK_P) ||
                          half_line >= (even_field ? `HL_PAL_EQ1_EVN : `HL_PAL_EQ1);
            end
        end else begin
            next_vs = half_line < `HL_NTSC_VS_END;
            next_eq = (half_line >= `HL_NTSC_EQ2_BEG && half_line < `HL_NTSC_EQ2_END) ||
                      half_line >= (even_field ? `HL_NTSC_EQ1_EVN : `HL_NTSC_EQ1);
            next_bp = half_line < `HL_BURST_END ||
                      half_line >= (even_field ? `HL_NTSC_EQ1_EVN : `HL_NTSC_EQ1);
            next_vb = half_line < (even_field ? `HL_NTSC_BLK_P + 10'd1 : `HL_NTSC_BLK_P) ||
                      half_line >= (even_field ? `HL_NTSC_EQ1_EVN : `HL_NTSC_EQ1);
        end
    end
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            eq_pulse     <= 1'b0;
            vsync_period <= 1'b0;
            burst_pause  <= 1'b0;
            vblank       <= 1'b0;
        end else begin
            eq_pulse     <= next_eq;
            vsync_period <= next_vs;
            burst_pause  <= next_bp;
            vblank       <= next_vb;
        end
    end
endmodule

// ---- verification/i2c_host_model.sv ----
// serial bus host model that writes the configuration registers
`timescale 1ns/10ps
module i2c_host_model (
    // serial bus, host side
    output reg  scl,
    output reg  sda_drv,
    input  wire sda_line
);
    localparam real Q = 31.25;

    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // data moves only while the clock is low
    task bit_out(input logic b);
        sda_drv = b;
        #Q scl = 1'b1;
        #(2 * Q) scl = 1'b0;
        #Q;
    endtask

    // releases the line for the slave, takes the answer at the rising edge
    task byte_out(input logic [7:0] v, output logic a);
        for (int i = 7; i >= 0; i--) bit_out(v[i]);
        sda_drv = 1'b1;
        #Q scl = 1'b1;
        a = ~sda_line;
        #(2 * Q) scl = 1'b0;
        #Q;
    endtask

    // one whole transaction per register; clock stands high between frames
    task frame(input logic [7:0] a, input logic [7:0] s, input logic [15:0] d, input int n,
               output logic [3:0] ak);
        ak = 4'h0;
        sda_drv = 1'b0;
        #Q scl = 1'b0;
        #Q;
        byte_out(a, ak[3]);
        byte_out(s, ak[2]);
        if (n > 1) byte_out(d[15:8], ak[1]);
        if (n > 0) byte_out(d[7:0], ak[0]);
        sda_drv = 1'b0;
        #Q scl = 1'b1;
        #Q sda_drv = 1'b1;
        #Q;
    endtask
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the video encoder timing and control core
`timescale 1ns/10ps
module testbench;
    typedef struct { logic [2:0] s; logic [9:0] t, h, a, z; } row_t;
    // design inputs
    logic       ref_clk = 1'b0;
    logic       rst_b = 1'b0;
    logic [2:0] std_pin = 3'h4;
    logic       master_pin = 1'b1;
    logic       intl_pin = 1'b1;
    logic       overlay_select_pin = 1'b0;
    logic       ext_hsync_b = 1'b1;
    logic       ext_vsync_b = 1'b1;
    // serial bus nets and design outputs
    wire        scl, sda_drv, sda_in, sda_out, sda_oe;
    wire [7:0]  mode_control_reg, command_reg;
    wire [2:0]  video_std, field_num, bar_index;
    wire [1:0]  lum_scale, src_sel;
    wire [9:0]  sample_count, half_line;
    wire        chroma_twos, ratio_411, setup_off, sync_master, subcarrier_to_horizontal_phase;
    wire        interlaced, hblank, eq_pulse, vsync_period, burst_pause, vblank;
    // bookkeeping
    int         fails = 0;
    int         num_checks = 0;
    logic [3:0] ak;
    row_t       rows [5];

    // pulled-up data line
    assign sda_in = sda_drv & ~(sda_oe & ~sda_out);

    video_encoder_timing_and_control u_video_encoder_timing_and_control (
        .ref_clk, .rst_b, .scl, .sda_in, .sda_out, .sda_oe, .std_pin, .master_pin, .intl_pin,
        .overlay_select_pin, .ext_hsync_b, .ext_vsync_b, .mode_control_reg,
        .command_reg, .video_std, .chroma_twos, .ratio_411, .setup_off, .sync_master,
        .subcarrier_to_horizontal_phase, .interlaced, .lum_scale, .src_sel, .sample_count,
        .half_line, .field_num, .hblank, .bar_index, .eq_pulse, .vsync_period, .burst_pause, .vblank);
    i2c_host_model u_i2c_host_model (.scl, .sda_drv, .sda_line(sda_in));

    always #5 ref_clk = ~ref_clk;

    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // register writes land well before the stop, so a few cycles suffice
    task automatic wr(input logic [7:0] a, input logic [7:0] s, input logic [15:0] d, input int n,
                      input logic [3:0] ea);
        u_i2c_host_model.frame(a, s, d, n, ak);
        repeat (4) @(posedge ref_clk);
        #1 chk(ak, ea);
    endtask

    // bounded wait on the line or field position
    task automatic at(input bit hl, input logic [9:0] n);
        int k;
        k = 0;
        while ((hl ? half_line : sample_count) !== n && k < 50000) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        if (k == 50000) chk(hl ? half_line : sample_count, n);
    endtask

    task automatic summarize;
        if (fails == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #1000000;
        fails++;
        summarize();
    end

    initial begin
        rows = '{'{3'h0, 10'h35A, 10'h07F, 10'h0D8, 10'h2EE}, '{3'h1, 10'h30C, 10'h074, 10'h0C5, 10'h2AA},
                 '{3'h2, 10'h38E, 10'h087, 10'h0E6, 10'h31B}, '{3'h4, 10'h360, 10'h08E, 10'h0E6, 10'h2F5},
                 '{3'h5, 10'h3B0, 10'h09B, 10'h0FB, 10'h33B}};
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        #1 chk(mode_control_reg, 8'h10);
        chk(command_reg, 8'h1B);
        chk(video_std, 3'h4);
        wr(8'h88, 8'h00, 16'h0048, 1, 4'hD);
        chk(mode_control_reg, 8'h48);
        chk({chroma_twos, ratio_411, sync_master}, 3'h7);
        wr(8'h80, 8'h01, 16'h12E4, 2, 4'hF);
        chk(command_reg, 8'h04);
        chk({src_sel, subcarrier_to_horizontal_phase, lum_scale, interlaced}, 6'h21);
        wr(8'h90, 8'h00, 16'h00FF, 1, 4'h0);
        wr(8'h89, 8'h00, 16'h00FF, 1, 4'h0);
        wr(8'h88, 8'h02, 16'h00FF, 1, 4'h8);
        chk(mode_control_reg, 8'h48);
        for (int k = 0; k < 4; k++) begin
            wr(8'h80, 8'h01, {8'h00, 6'h06, k[1:0]}, 1, 4'hD);
            chk({src_sel, lum_scale}, {2'h0, k[1:0]});
        end
        @(posedge ref_clk);
        overlay_select_pin <= 1'b1;
        repeat (5) @(posedge ref_clk);
        #1 chk(src_sel, 2'h1);
        at(1, 10'h020);
        @(posedge ref_clk);
        intl_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1 chk(interlaced, 1'b0);
        @(posedge ref_clk);
        intl_pin <= 1'b1;
        // override on, master, one row per standard
        foreach (rows[i]) begin
            wr(8'h88, 8'h00, {8'h00, 5'h12, rows[i].s}, 1, 4'hD);
            chk(video_std, rows[i].s);
            at(0, 10'h000);
            at(0, rows[i].h - 10'h002);
            chk(hblank, 1'b1);
            at(0, rows[i].h + 10'h003);
            chk({hblank, bar_index}, 4'h0);
            at(0, rows[i].a + 10'h003);
            chk(bar_index, 3'h1);
            at(0, rows[i].z + 10'h003);
            chk(bar_index, 3'h7);
            at(0, rows[i].t - 10'h001);
            @(posedge ref_clk);
            #1 chk(sample_count, 10'h000);
        end
        wr(8'h80, 8'h01, 16'h0013, 1, 4'hD);
        chk(interlaced, 1'b0);
        wr(8'h88, 8'h00, 16'h0085, 1, 4'hD);
        chk(sync_master, 1'b0);
        // slave mode: external syncs realign both counters, which also keeps the field wait short
        ext_hsync_b <= 1'b0;
        ext_vsync_b <= 1'b0;
        repeat (3) @(posedge ref_clk);
        ext_hsync_b <= 1'b1;
        ext_vsync_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 chk(half_line, 10'h000);
        wr(8'h88, 8'h00, 16'h00B5, 1, 4'hD);
        chk({mode_control_reg[5], setup_off}, 2'h2);
        wr(8'h80, 8'h01, 16'h001B, 1, 4'hD);
        at(1, 10'h02E);
        chk(vblank, 1'b0);
        // bar bit lands at once, level waits for the next blanking
        wr(8'h80, 8'h01, 16'h001C, 1, 4'hD);
        chk({command_reg[2], lum_scale}, 3'h7);
        at(1, 10'h066);
        chk(lum_scale, 2'h3);
        summarize();
    end
endmodule

// ---- verification/video_encoder_properties.sv ----
// checker for the field timing, line timing and register port
`timescale 1ns/10ps
module video_encoder_properties (
    // clock and reset
    input wire       ref_clk,
    input wire       rst_b,
    // watched ports
    input wire       scl,
    input wire [2:0] std_pin,
    input wire       sda_oe,
    input wire [7:0] mode_control_reg,
    input wire [7:0] command_reg,
    input wire [2:0] video_std,
    input wire       sync_master,
    input wire       interlaced,
    input wire [1:0] src_sel,
    input wire [9:0] sample_count,
    input wire [9:0] half_line,
    input wire       hblank,
    input wire       eq_pulse,
    input wire       vsync_period,
    input wire       burst_pause,
    input wire       vblank
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    function automatic [9:0] total(input [2:0] s);
        case (s)
            3'h1: total = 10'h30C;
            3'h2: total = 10'h38E;
            3'h4: total = 10'h360;
            3'h5: total = 10'h3B0;
            default: total = 10'h35A;
        endcase
    endfunction

    function automatic [9:0] hb(input [2:0] s);
        case (s)
            3'h1: hb = 10'h074;
            3'h2: hb = 10'h087;
            3'h4: hb = 10'h08E;
            3'h5: hb = 10'h09B;
            default: hb = 10'h07F;
        endcase
    endfunction

    // interior half-line points only: the edges may lag by one register
    a_pal_vsync_open: assert property (video_std[2] && half_line == 10'h001 |-> vsync_period)
        else $error("vsync low at start of field");
    a_pal_eq_second: assert property (video_std[2] && half_line == 10'h005 |->
        eq_pulse && !vsync_period && burst_pause)
        else $error("second equalizing interval wrong");
    a_pal_blank_hold: assert property (video_std[2] && interlaced && half_line == 10'h01E |->
        vblank && !eq_pulse && !vsync_period)
        else $error("blanking wrong inside field start");
    a_pal_active_open: assert property (video_std[2] && half_line == 10'h064 |-> !vblank && !burst_pause)
        else $error("blanking or burst pause in active lines");
    a_line_total: assert property (sync_master && $past(sync_master) && video_std == $past(video_std)
        && video_std == $past(video_std, 2) && sample_count < $past(sample_count) |->
        sample_count == 10'h000 && $past(sample_count) == total(video_std) - 10'h001)
        else $error("line length wrong");
    a_hblank_end: assert property ($fell(hblank) && video_std == $past(video_std, 2) |->
        sample_count == hb(video_std) || sample_count == hb(video_std) + 10'h001)
        else $error("horizontal blanking ends at wrong sample");
    a_ack_slot: assert property ($rose(sda_oe) |-> !scl ##1 sda_oe [*3])
        else $error("acknowledge outside clock low phase");
    a_cmd_undef: assert property (command_reg[7:5] == 3'h0)
        else $error("undefined command bits set");
    a_bar_wins: assert property (command_reg[2] [*3] |-> src_sel == 2'h2)
        else $error("color bar not selected");
    a_pin_straps: assert property ((!mode_control_reg[7] && $stable(std_pin)) [*4] |->
        video_std == std_pin)
        else $error("standard not taken from pins");

    c_ack: cover property ($rose(sda_oe));
    c_vblank_end: cover property ($fell(vblank));
    c_bar_out: cover property (src_sel == 2'h2);
endmodule

bind video_encoder_timing_and_control video_encoder_properties u_video_encoder_properties (
    .ref_clk, .rst_b, .scl, .std_pin, .sda_oe, .mode_control_reg, .command_reg, .video_std,
    .sync_master, .interlaced, .src_sel, .sample_count, .half_line, .hblank, .eq_pulse,
    .vsync_period, .burst_pause, .vblank);
